// >>> elev_safety_supervisor.sv
// Dual-channel elevator safety supervisor with an APB register slave.
//
// The APB interface to the registers and the register addresses were decided locally.
`timescale 1ns/1ps
`include "elev_safety_defs.svh"

module elev_safety_supervisor #(
  parameter logic [39:0] STOP_CLEAR_CYCLES = `STOP_CLEAR_CYC,
  parameter logic [39:0] BYPASS_LIMIT_CYCLES = `BYPASS_LIMIT_CYC,
  parameter logic [39:0] JUMPER_LIMIT_CYCLES = `JUMPER_LIMIT_CYC
) (
  // Clock and reset
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  // APB slave
  input wire logic PSEL_I,
  input wire logic PENABLE_I,
  input wire logic PWRITE_I,
  input wire logic [7:0] PADDR_I,
  input wire logic [31:0] PWDATA_I,
  output logic [31:0] PRDATA_O,
  output logic PREADY_O,
  output logic PSLVERR_O,
  // Speed and hoistway sensors, one set per channel
  input wire logic [15:0] SPEED_A_I,
  input wire logic [15:0] SPEED_B_I,
  input wire logic [1:0] UPPER_EMERGENCY_TERMINAL_SWITCH_I,
  input wire logic [1:0] LOWER_EMERGENCY_TERMINAL_SWITCH_I,
  input wire logic [1:0] SAFETY_BOARD_BUS_WRITE_FAIL_I,
  // Car and door state
  input wire logic AT_FLOOR_I,
  input wire logic HOISTWAY_DOOR_OPEN_I,
  input wire logic CAR_GATE_OPEN_I,
  input wire logic MAIN_CONTROLLER_PROCESSOR_MOVE_I,
  // Operator controls and modes
  input wire logic FAULT_RESET_I,
  input wire logic BYPASS_SWITCH_I,
  input wire logic BYPASS_JUMPER_I,
  input wire logic INSPECTION_I,
  input wire logic TEST_MODE_I,
  input wire logic MR_INSPECTION_I,
  // Safety strings, high when closed
  input wire logic CAR_STRING_I,
  input wire logic HOISTWAY_STRING_I,
  // Stored configuration checks
  input wire logic CONFIG_CHECKSUM_BAD_I,
  input wire logic CONFIG_LEARN_FAIL_I,
  input wire logic CONFIG_MISMATCH_I,
  input wire logic INVENTORY_MISMATCH_I,
  // Contactor drives, high to energise
  output logic MOTOR_CONTACTOR_O,
  output logic BRAKE_CONTACTOR_O,
  output logic ROPE_BRAKE_O,
  output logic RUN_PERMIT_O
);

  // ----------------------------------------
  // Input synchroniser
  // ----------------------------------------
  // The speed words are sampled as plain bits; a value caught mid-change lasts one cycle and only
  // matters at a threshold, which is an accepted limitation of a sensor with no strobe.
  elev_safety_pkg::pins_t pins_raw;
  elev_safety_pkg::pins_t pins_meta_q;
  elev_safety_pkg::pins_t pin_q;

  assign pins_raw = '{
    speed_a: SPEED_A_I,
    speed_b: SPEED_B_I,
    upper_emergency_terminal_switch: UPPER_EMERGENCY_TERMINAL_SWITCH_I,
    lower_emergency_terminal_switch: LOWER_EMERGENCY_TERMINAL_SWITCH_I,
    bus_write_fail: SAFETY_BOARD_BUS_WRITE_FAIL_I,
    at_floor: AT_FLOOR_I,
    door_open: HOISTWAY_DOOR_OPEN_I,
    gate_open: CAR_GATE_OPEN_I,
    move_cmd: MAIN_CONTROLLER_PROCESSOR_MOVE_I,
    fault_reset: FAULT_RESET_I,
    bypass_switch: BYPASS_SWITCH_I,
    jumper: BYPASS_JUMPER_I,
    inspection: INSPECTION_I,
    test_mode: TEST_MODE_I,
    mr_inspection: MR_INSPECTION_I,
    car_string: CAR_STRING_I,
    hoist_string: HOISTWAY_STRING_I,
    checksum_bad: CONFIG_CHECKSUM_BAD_I,
    learn_fail: CONFIG_LEARN_FAIL_I,
    param_mismatch: CONFIG_MISMATCH_I,
    inventory_mismatch: INVENTORY_MISMATCH_I
  };

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pins_meta_q <= '0;
      pin_q <= '0;
    end else begin
      pins_meta_q <= pins_raw;
      pin_q <= pins_meta_q;
    end
  end

  // ----------------------------------------
  // Configuration registers
  // ----------------------------------------
  elev_safety_pkg::apb_req_t req;
  logic [`CTRL_WIDTH-1:0] ctrl_q;
  logic [15:0] cos_limit_q;
  logic [15:0] los_limit_q;
  logic [15:0] contract_q;
  logic wr_en;
  logic map_hit;

  assign req = '{psel: PSEL_I, penable: PENABLE_I, pwrite: PWRITE_I, paddr: PADDR_I, pwdata: PWDATA_I};
  assign wr_en = req.psel && req.penable && PREADY_O && req.pwrite && !PSLVERR_O;
  assign map_hit = (req.paddr[1:0] == 2'h0) && (req.paddr <= `REG_STATUS);

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      ctrl_q <= `RST_CTRL;
      cos_limit_q <= `RST_COS_LIMIT;
      los_limit_q <= `RST_LOS_LIMIT;
      contract_q <= `RST_CONTRACT_SPEED;
    end else if (wr_en) begin
      case (req.paddr)
        `REG_CTRL: ctrl_q <= req.pwdata[`CTRL_WIDTH-1:0];
        `REG_COS_LIMIT: cos_limit_q <= req.pwdata[15:0];
        `REG_LOS_LIMIT: los_limit_q <= req.pwdata[15:0];
        `REG_CONTRACT_SPEED: contract_q <= req.pwdata[15:0];
        default: ;
      endcase
    end
  end

  // ----------------------------------------
  // Safety channels A and B
  // ----------------------------------------
  logic [`CH_FLT_W-1:0] ch_flt_q [2];
  logic [1:0] ch_estop;
  logic [1:0] ch_inhibit;
  logic [1:0] ch_restart_block;
  logic [1:0] ch_um;
  logic [1:0] ch_bp_ok;
  logic [1:0] ch_moving;
  logic at_floor_prev_q;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      at_floor_prev_q <= 1'b0;
    end else begin
      at_floor_prev_q <= pin_q.at_floor;
    end
  end

  for (genvar ch = 0; ch < 2; ch++) begin : g_chan
    logic [15:0] spd;
    logic over_share;
    logic stopped_long;
    logic [39:0] stop_cnt_q;
    logic [39:0] byp_cnt_q;
    logic [39:0] jmp_cnt_q;
    logic byp_expired;
    logic [`CH_FLT_W-1:0] set;
    logic [`CH_FLT_W-1:0] f;

    assign spd = (ch == 0) ? pin_q.speed_a : pin_q.speed_b;
    assign f = ch_flt_q[ch];
    assign ch_moving[ch] = (spd != 16'h0000);
    assign over_share = (24'(spd) * 24'h000064) > (24'(contract_q) * `TERM_SHARE_PCT);
    assign stopped_long = (stop_cnt_q >= STOP_CLEAR_CYCLES);
    assign byp_expired = (byp_cnt_q >= BYPASS_LIMIT_CYCLES);
    assign ch_bp_ok[ch] = pin_q.bypass_switch && (pin_q.inspection || !f[`FLT_BTO]);

    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        stop_cnt_q <= '0;
        byp_cnt_q <= '0;
        jmp_cnt_q <= '0;
      end else begin
        if (ch_moving[ch]) begin
          stop_cnt_q <= '0;
        end else if (!stopped_long) begin
          stop_cnt_q <= stop_cnt_q + 40'h1;
        end
        if (!pin_q.bypass_switch) begin
          byp_cnt_q <= '0;
        end else if (!pin_q.inspection && !byp_expired) begin
          byp_cnt_q <= byp_cnt_q + 40'h1;
        end
        if (!pin_q.jumper) begin
          jmp_cnt_q <= '0;
        end else if (jmp_cnt_q < JUMPER_LIMIT_CYCLES) begin
          jmp_cnt_q <= jmp_cnt_q + 40'h1;
        end
      end
    end

    always_comb begin
      set = '0;
      set[`FLT_UPPER_EMERGENCY_TERMINAL_SWITCH] = pin_q.upper_emergency_terminal_switch[ch] && over_share;
      set[`FLT_LOWER_EMERGENCY_TERMINAL_SWITCH] = pin_q.lower_emergency_terminal_switch[ch] && over_share;
      set[`FLT_COS] = spd > cos_limit_q;
      set[`FLT_IOS] = spd > `INSP_SPEED_FPM;
      set[`FLT_LOS] = spd > los_limit_q;
      set[`FLT_UM] = at_floor_prev_q && !pin_q.at_floor && pin_q.door_open && pin_q.gate_open
                     && !pin_q.move_cmd;
      set[`FLT_BTO] = pin_q.bypass_switch && !pin_q.inspection && byp_expired;
    end

    // A raise in the same cycle as a clear condition always wins.
    always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
      if (!NRST_I) begin
        ch_flt_q[ch] <= '0;
      end else begin
        for (int b = `FLT_UPPER_EMERGENCY_TERMINAL_SWITCH; b <= `FLT_LOS; b++) begin
          ch_flt_q[ch][b] <= set[b] || (f[b] && !stopped_long);
        end
        ch_flt_q[ch][`FLT_UM] <= set[`FLT_UM] || (f[`FLT_UM] && !pin_q.fault_reset);
        ch_flt_q[ch][`FLT_BUS] <= pin_q.bus_write_fail[ch];
        ch_flt_q[ch][`FLT_JTO] <= pin_q.jumper && (jmp_cnt_q >= JUMPER_LIMIT_CYCLES);
        ch_flt_q[ch][`FLT_BTO] <= set[`FLT_BTO] || (f[`FLT_BTO] && pin_q.bypass_switch);
      end
    end

    logic term_live;
    logic cos_live;
    logic los_live;
    assign term_live = (f[`FLT_UPPER_EMERGENCY_TERMINAL_SWITCH] || f[`FLT_LOWER_EMERGENCY_TERMINAL_SWITCH]) && !(ctrl_q[`CTRL_BP_TERM] && ch_bp_ok[ch]);
    assign cos_live = f[`FLT_COS] && !(ctrl_q[`CTRL_BP_COS] && ch_bp_ok[ch]);
    assign los_live = f[`FLT_LOS] && !(ctrl_q[`CTRL_BP_LOS] && ch_bp_ok[ch]);
    assign ch_estop[ch] = term_live || cos_live || f[`FLT_IOS] || los_live || f[`FLT_UM]
                          || f[`FLT_BUS] || f[`FLT_BTO];
    assign ch_inhibit[ch] = ch_estop[ch];
    assign ch_restart_block[ch] = f[`FLT_JTO];
    assign ch_um[ch] = f[`FLT_UM];
  end

  // ----------------------------------------
  // Shared faults and car reaction
  // ----------------------------------------
  logic learn_flt_q;
  logic running;
  logic str_bp_mode;
  logic c_block;
  logic h_block;
  logic estop;
  logic inhibit;
  logic run_permit_q;
  logic motor_q;
  logic brake_q;
  logic rope_q;
  logic estop_q;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      learn_flt_q <= 1'b0;
    end else begin
      learn_flt_q <= pin_q.learn_fail || (learn_flt_q && !pin_q.fault_reset);
    end
  end

  assign running = |ch_moving;
  assign str_bp_mode = pin_q.test_mode || pin_q.mr_inspection;
  assign c_block = !pin_q.car_string && !(ctrl_q[`CTRL_BP_CSTR] && str_bp_mode);
  assign h_block = !pin_q.hoist_string && !(ctrl_q[`CTRL_BP_HSTR] && str_bp_mode);
  assign estop = (|ch_estop) || (running && (c_block || h_block));
  assign inhibit = (|ch_inhibit) || c_block || h_block || pin_q.checksum_bad
                   || learn_flt_q || pin_q.param_mismatch
                   || pin_q.inventory_mismatch
                   || ((|ch_restart_block) && !running);

  // Both contactors fall in the same edge; there is no ramp because a stopping sequence would
  // keep the motor powered through the very fault that demands its removal.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      run_permit_q <= 1'b0;
      motor_q <= 1'b0;
      brake_q <= 1'b0;
      rope_q <= 1'b0;
      estop_q <= 1'b0;
    end else begin
      run_permit_q <= !inhibit;
      estop_q <= estop;
      motor_q <= pin_q.move_cmd && !estop && !inhibit;
      brake_q <= pin_q.move_cmd && !estop && !inhibit;
      rope_q <= !(ctrl_q[`CTRL_ROPE_FITTED] && (|ch_um));
    end
  end

  assign MOTOR_CONTACTOR_O = motor_q;
  assign BRAKE_CONTACTOR_O = brake_q;
  assign ROPE_BRAKE_O = rope_q;
  assign RUN_PERMIT_O = run_permit_q;

  // ----------------------------------------
  // Fault events
  // ----------------------------------------
  logic [`FLT_W-1:0] flt_all;
  logic [`FLT_W-1:0] flt_prev_q;
  logic [`FLT_W-1:0] evt_on_q;
  logic [`FLT_W-1:0] evt_off_q;
  logic [`FLT_W-1:0] w1c_on;
  logic [`FLT_W-1:0] w1c_off;

  assign flt_all = {pin_q.inventory_mismatch, pin_q.param_mismatch, learn_flt_q, pin_q.checksum_bad,
                    !pin_q.hoist_string, !pin_q.car_string, ch_flt_q[1], ch_flt_q[0]};
  assign w1c_on = (wr_en && req.paddr == `REG_EVT_ON) ? req.pwdata[`FLT_W-1:0] : '0;
  assign w1c_off = (wr_en && req.paddr == `REG_EVT_OFF) ? req.pwdata[`FLT_W-1:0] : '0;

  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      flt_prev_q <= '0;
      evt_on_q <= '0;
      evt_off_q <= '0;
    end else begin
      flt_prev_q <= flt_all;
      evt_on_q <= (evt_on_q & ~w1c_on) | (flt_all & ~flt_prev_q);
      evt_off_q <= (evt_off_q & ~w1c_off) | (~flt_all & flt_prev_q);
    end
  end

  // ----------------------------------------
  // APB read and answer
  // ----------------------------------------
  logic [31:0] rd_word;
  logic [31:0] prdata_q;
  logic pready_q;
  logic pslverr_q;

  always_comb begin
    rd_word = 32'h00000000;
    case (req.paddr)
      `REG_CTRL: rd_word = 32'(ctrl_q);
      `REG_COS_LIMIT: rd_word = 32'(cos_limit_q);
      `REG_LOS_LIMIT: rd_word = 32'(los_limit_q);
      `REG_CONTRACT_SPEED: rd_word = 32'(contract_q);
      `REG_FAULT: rd_word = 32'(flt_all);
      `REG_EVT_ON: rd_word = 32'(evt_on_q);
      `REG_EVT_OFF: rd_word = 32'(evt_off_q);
      `REG_STATUS: begin
        rd_word[`ST_MOTOR] = motor_q;
        rd_word[`ST_BRAKE] = brake_q;
        rd_word[`ST_ROPE] = rope_q;
        rd_word[`ST_RUN_PERMIT] = run_permit_q;
        rd_word[`ST_ESTOP] = estop_q;
        rd_word[`ST_BP_OK_A] = ch_bp_ok[0];
        rd_word[`ST_BP_OK_B] = ch_bp_ok[1];
      end
      default: rd_word = 32'h00000000;
    endcase
  end

  // Every transfer completes with no wait state; the answer is registered in the setup cycle so that it comes from flip-flops.
  always_ff @(posedge REF_CLK_I or negedge NRST_I) begin
    if (!NRST_I) begin
      pready_q <= 1'b0;
      pslverr_q <= 1'b0;
      prdata_q <= '0;
    end else begin
      pready_q <= req.psel && !req.penable;
      pslverr_q <= req.psel && !req.penable && !map_hit;
      if (req.psel && !req.penable && !req.pwrite && map_hit) begin
        prdata_q <= rd_word;
      end else if (req.psel && !req.penable) begin
        prdata_q <= '0;
      end
    end
  end

  assign PRDATA_O = prdata_q;
  assign PREADY_O = pready_q;
  assign PSLVERR_O = pslverr_q;

endmodule

// >>> elev_safety_defs.svh
// Register offsets, field positions, reset values and timing counts of the safety supervisor.
`ifndef ELEV_SAFETY_DEFS_SVH
`define ELEV_SAFETY_DEFS_SVH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define REG_CTRL 8'h00
`define REG_COS_LIMIT 8'h04
`define REG_LOS_LIMIT 8'h08
`define REG_CONTRACT_SPEED 8'h0c
`define REG_FAULT 8'h10
`define REG_EVT_ON 8'h14
`define REG_EVT_OFF 8'h18
`define REG_STATUS 8'h1c

// ----------------------------------------
// Control fields
// ----------------------------------------
`define CTRL_BP_TERM 0
`define CTRL_BP_COS 1
`define CTRL_BP_LOS 2
`define CTRL_BP_CSTR 3
`define CTRL_BP_HSTR 4
`define CTRL_ROPE_FITTED 5
`define CTRL_WIDTH 6

// ----------------------------------------
// Fault fields, per channel and shared
// ----------------------------------------
`define FLT_UPPER_EMERGENCY_TERMINAL_SWITCH 0
`define FLT_LOWER_EMERGENCY_TERMINAL_SWITCH 1
`define FLT_COS 2
`define FLT_IOS 3
`define FLT_LOS 4
`define FLT_UM 5
`define FLT_BUS 6
`define FLT_JTO 7
`define FLT_BTO 8
`define CH_FLT_W 9
`define GFLT_CSTR 18
`define GFLT_HSTR 19
`define GFLT_CHKSUM 20
`define GFLT_LEARN 21
`define GFLT_MISMATCH 22
`define GFLT_INVENTORY 23
`define FLT_W 24

// ----------------------------------------
// Status fields
// ----------------------------------------
`define ST_MOTOR 0
`define ST_BRAKE 1
`define ST_ROPE 2
`define ST_RUN_PERMIT 3
`define ST_ESTOP 4
`define ST_BP_OK_A 5
`define ST_BP_OK_B 6

// ----------------------------------------
// Reset values and speed figures
// ----------------------------------------
`define RST_CTRL 6'h00
`define RST_COS_LIMIT 16'hffff
`define RST_LOS_LIMIT 16'hffff
`define RST_CONTRACT_SPEED 16'hffff
`define INSP_SPEED_FPM 16'h0096
`define TERM_SHARE_PCT 24'h00005f

// ----------------------------------------
// Timing
// ----------------------------------------
`define CLK_MHZ 125
`define STOP_CLEAR_MS 5000
`define BYPASS_LIMIT_MIN 15
`define JUMPER_LIMIT_MIN 15
`define STOP_CLEAR_CYC (40'(`STOP_CLEAR_MS) * 40'd1000 * 40'(`CLK_MHZ))
`define BYPASS_LIMIT_CYC (40'(`BYPASS_LIMIT_MIN) * 40'd60000000 * 40'(`CLK_MHZ))
`define JUMPER_LIMIT_CYC (40'(`JUMPER_LIMIT_MIN) * 40'd60000000 * 40'(`CLK_MHZ))

`endif

// >>> elev_safety_pkg.sv
// Types shared by the safety supervisor.
package elev_safety_pkg;

  // ----------------------------------------
  // Bus request
  // ----------------------------------------
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [7:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  // ----------------------------------------
  // Pin inputs, synchronised as one word
  // ----------------------------------------
  typedef struct packed {
    logic [15:0] speed_a;
    logic [15:0] speed_b;
    logic [1:0] upper_emergency_terminal_switch;
    logic [1:0] lower_emergency_terminal_switch;
    logic [1:0] bus_write_fail;
    logic at_floor;
    logic door_open;
    logic gate_open;
    logic move_cmd;
    logic fault_reset;
    logic bypass_switch;
    logic jumper;
    logic inspection;
    logic test_mode;
    logic mr_inspection;
    logic car_string;
    logic hoist_string;
    logic checksum_bad;
    logic learn_fail;
    logic param_mismatch;
    logic inventory_mismatch;
  } pins_t;

endpackage

// >>> elev_safety_monitor.sv
// Concurrent checks on the pins of the elevator safety supervisor.
`timescale 1ns/1ps
module elev_safety_monitor (
  // Clock, reset and bus
  input wire logic REF_CLK_I,
  input wire logic NRST_I,
  input wire logic PSEL_I,
  // Sensors and operator controls
  input wire logic [15:0] SPEED_A_I,
  input wire logic [15:0] SPEED_B_I,
  input wire logic [1:0] SAFETY_BOARD_BUS_WRITE_FAIL_I,
  input wire logic FAULT_RESET_I,
  input wire logic TEST_MODE_I,
  input wire logic MR_INSPECTION_I,
  input wire logic CAR_STRING_I,
  input wire logic HOISTWAY_STRING_I,
  input wire logic CONFIG_CHECKSUM_BAD_I,
  input wire logic CONFIG_LEARN_FAIL_I,
  input wire logic CONFIG_MISMATCH_I,
  input wire logic INVENTORY_MISMATCH_I,
  // Contactor drives
  input wire logic MOTOR_CONTACTOR_O,
  input wire logic BRAKE_CONTACTOR_O,
  input wire logic ROPE_BRAKE_O,
  input wire logic RUN_PERMIT_O
);
  // ----------------------------------------
  // Checks
  // ----------------------------------------
  // Causes must hold five samples, because the input synchronisers delay every pin.
  default clocking cb @(posedge REF_CLK_I); endclocking
  default disable iff (!NRST_I);
  a_contactors_paired: assert property (MOTOR_CONTACTOR_O == BRAKE_CONTACTOR_O)
    else $error("motor and brake contactors differ");
  a_config_inhibit: assert property (
    (CONFIG_CHECKSUM_BAD_I || INVENTORY_MISMATCH_I) [*5] |-> !RUN_PERMIT_O && !MOTOR_CONTACTOR_O)
    else $error("car may move with bad stored configuration");
  a_learn_inhibit: assert property (CONFIG_LEARN_FAIL_I [*5] |-> !RUN_PERMIT_O)
    else $error("run permitted after failed learn");
  a_mismatch_inhibit: assert property (CONFIG_MISMATCH_I [*5] |-> !RUN_PERMIT_O)
    else $error("run permitted with parameter mismatch");
  a_string_inhibit: assert property (
    ((!CAR_STRING_I || !HOISTWAY_STRING_I) && !TEST_MODE_I && !MR_INSPECTION_I) [*5] |-> !RUN_PERMIT_O)
    else $error("run permitted with a safety string open");
  a_insp_speed_a: assert property ((SPEED_A_I > 16'h0096) [*5] |-> !MOTOR_CONTACTOR_O)
    else $error("contactor held above inspection limit on channel A");
  a_insp_speed_b: assert property ((SPEED_B_I > 16'h0096) [*5] |-> !MOTOR_CONTACTOR_O)
    else $error("contactor held above inspection limit on channel B");
  a_bus_stop: assert property ((|SAFETY_BOARD_BUS_WRITE_FAIL_I) [*5] |-> !MOTOR_CONTACTOR_O)
    else $error("contactor held while a channel cannot write its bus");
  a_motion_latched: assert property (
    !ROPE_BRAKE_O && $past(NRST_I) && !PSEL_I && !$past(PSEL_I) && !FAULT_RESET_I && !$past(FAULT_RESET_I)
    && !$past(FAULT_RESET_I, 2) && !$past(FAULT_RESET_I, 3) |=> !ROPE_BRAKE_O)
    else $error("rope brake restored without the reset button");
endmodule

bind elev_safety_supervisor elev_safety_monitor mon_u (
  .REF_CLK_I, .NRST_I, .PSEL_I, .SPEED_A_I, .SPEED_B_I, .SAFETY_BOARD_BUS_WRITE_FAIL_I, .FAULT_RESET_I,
  .TEST_MODE_I, .MR_INSPECTION_I, .CAR_STRING_I, .HOISTWAY_STRING_I, .CONFIG_CHECKSUM_BAD_I,
  .CONFIG_LEARN_FAIL_I, .CONFIG_MISMATCH_I, .INVENTORY_MISMATCH_I, .MOTOR_CONTACTOR_O,
  .BRAKE_CONTACTOR_O, .ROPE_BRAKE_O, .RUN_PERMIT_O
);

// >>> elev_safety_hoistway.sv
// Model of the hoistway sensors, operator panel and main controller around the supervisor.
`timescale 1ns/1ps
module elev_safety_hoistway (
  // Clock
  input wire logic clk_i,
  // Requested sensor and panel states
  input wire elev_safety_pkg::pins_t req_i,
  // Pins seen by the supervisor
  output elev_safety_pkg::pins_t pins_o
);
  // ----------------------------------------
  // Sensor update
  // ----------------------------------------
  // Contacts change just after an edge, so nothing races the supervisor's sampling.
  // The operator holds the reset button and the bypass switch as long as asked.
  always @(posedge clk_i) begin
    pins_o <= req_i;
  end
endmodule

// >>> elevator_safety_fault_supervisor_bench.sv
// Self-checking bench for the elevator safety supervisor.
`timescale 1ns/1ps
`include "elev_safety_defs.svh"
module elevator_safety_fault_supervisor_bench;
  // ----------------------------------------
  // Signals and instances
  // ----------------------------------------
  logic clk, nrst, psel, pen, pwr, err, pready, pslverr;
  logic [7:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  elev_safety_pkg::pins_t cmd, pins;
  int mismatches = 0;
  int tests_run = 0;
  int cyc = 0;
  elev_safety_hoistway car_u (.clk_i(clk), .req_i(cmd), .pins_o(pins));
  // Short counts keep the stop, bypass and jumper timers inside a brief run.
  elev_safety_supervisor #(
    .STOP_CLEAR_CYCLES(40'h14), .BYPASS_LIMIT_CYCLES(40'h32), .JUMPER_LIMIT_CYCLES(40'h28)
  ) dut_u (
    .REF_CLK_I(clk), .NRST_I(nrst), .PSEL_I(psel), .PENABLE_I(pen), .PWRITE_I(pwr), .PADDR_I(paddr),
    .PWDATA_I(pwdata), .PRDATA_O(prdata), .PREADY_O(pready), .PSLVERR_O(pslverr),
    .SPEED_A_I(pins.speed_a), .SPEED_B_I(pins.speed_b),
    .UPPER_EMERGENCY_TERMINAL_SWITCH_I(pins.upper_emergency_terminal_switch),
    .LOWER_EMERGENCY_TERMINAL_SWITCH_I(pins.lower_emergency_terminal_switch),
    .SAFETY_BOARD_BUS_WRITE_FAIL_I(pins.bus_write_fail), .AT_FLOOR_I(pins.at_floor),
    .HOISTWAY_DOOR_OPEN_I(pins.door_open), .CAR_GATE_OPEN_I(pins.gate_open),
    .MAIN_CONTROLLER_PROCESSOR_MOVE_I(pins.move_cmd), .FAULT_RESET_I(pins.fault_reset),
    .BYPASS_SWITCH_I(pins.bypass_switch), .BYPASS_JUMPER_I(pins.jumper), .INSPECTION_I(pins.inspection),
    .TEST_MODE_I(pins.test_mode), .MR_INSPECTION_I(pins.mr_inspection), .CAR_STRING_I(pins.car_string),
    .HOISTWAY_STRING_I(pins.hoist_string), .CONFIG_CHECKSUM_BAD_I(pins.checksum_bad),
    .CONFIG_LEARN_FAIL_I(pins.learn_fail), .CONFIG_MISMATCH_I(pins.param_mismatch),
    .INVENTORY_MISMATCH_I(pins.inventory_mismatch), .MOTOR_CONTACTOR_O(), .BRAKE_CONTACTOR_O(),
    .ROPE_BRAKE_O(), .RUN_PERMIT_O()
  );
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      mismatches = mismatches + 1;
      report_and_stop;
    end
  end
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic report_and_stop;
    $display("comparisons %0d mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    tests_run = tests_run + 1;
    if (g !== e) begin
      mismatches = mismatches + 1;
      $display("ERROR %s expected %h seen %h", n, e, g);
    end
  endtask
  // Read data and the error flag are taken at the edge where pready is seen high.
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    @(posedge clk);
    while (pready !== 1'b1) @(posedge clk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    pen <= 1'b0;
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic bchk(input string n, input logic [7:0] a, input int b, input logic e);
    apb(1'b0, a, 32'h0);
    chk(n, {31'h0, e}, {31'h0, rd[b]});
  endtask
  task automatic spd(input logic [15:0] a, input logic [15:0] b, input logic [31:0] e);
    cmd.speed_a <= a;
    cmd.speed_b <= b;
    settle(8);
    apb(1'b0, `REG_FAULT, 32'h0);
    chk("fault raised", e, rd);
    apb(1'b0, `REG_EVT_ON, 32'h0);
    chk("events on", e, rd);
    cmd.speed_a <= 16'h0000;
    cmd.speed_b <= 16'h0000;
    settle(30);
    apb(1'b0, `REG_FAULT, 32'h0);
    chk("fault cleared", 32'h0, rd);
    apb(1'b0, `REG_EVT_OFF, 32'h0);
    chk("events off", e, rd);
    apb(1'b1, `REG_EVT_ON, 32'hffffffff);
    apb(1'b1, `REG_EVT_OFF, 32'hffffffff);
  endtask
  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial begin
    {psel, pen, pwr, paddr, pwdata} = '0;
    nrst = 1'b0;
    cmd = '0;
    cmd.at_floor = 1'b1;
    cmd.car_string = 1'b1;
    cmd.hoist_string = 1'b1;
    repeat (2) @(posedge clk);
    nrst <= 1'b1;
    settle(6);
    bchk("ctrl reset", `REG_CTRL, 0, 1'b0);
    apb(1'b0, `REG_COS_LIMIT, 32'h0);
    chk("limit reset", 32'h0000ffff, rd);
    apb(1'b0, 8'h20, 32'h0);
    chk("unmapped error", 32'h1, {31'h0, err});
    apb(1'b1, `REG_EVT_ON, 32'hffffffff);
    apb(1'b1, `REG_EVT_OFF, 32'hffffffff);
    apb(1'b1, `REG_CONTRACT_SPEED, 32'h64);
    for (int i = 0; i < 2; i++) begin
      cmd.upper_emergency_terminal_switch <= i ? 2'b00 : 2'b11;
      cmd.lower_emergency_terminal_switch <= i ? 2'b11 : 2'b00;
      spd(16'h005f, 16'h005f, 32'h0);
      spd(16'h0060, 16'h0060, 32'h201 << i);
    end
    cmd.lower_emergency_terminal_switch <= 2'b00;
    cmd.upper_emergency_terminal_switch <= 2'b01;
    spd(16'h0060, 16'h0060, 32'h1);
    cmd.upper_emergency_terminal_switch <= 2'b00;
    apb(1'b1, `REG_COS_LIMIT, 32'h78);
    spd(16'h0079, 16'h0078, 32'h4);
    apb(1'b1, `REG_COS_LIMIT, 32'hffff);
    apb(1'b1, `REG_LOS_LIMIT, 32'h64);
    spd(16'h0064, 16'h0065, 32'h2000);
    apb(1'b1, `REG_LOS_LIMIT, 32'hffff);
    spd(16'h0097, 16'h0096, 32'h8);
    spd(16'h0096, 16'h0097, 32'h1000);
    apb(1'b1, `REG_CTRL, 32'h1);
    cmd.bypass_switch <= 1'b1;
    cmd.move_cmd <= 1'b1;
    cmd.upper_emergency_terminal_switch <= 2'b11;
    cmd.speed_a <= 16'h0060;
    cmd.speed_b <= 16'h0060;
    settle(8);
    bchk("estop bypassed", `REG_STATUS, 4, 1'b0);
    bchk("motor bypassed", `REG_STATUS, 0, 1'b1);
    settle(60);
    bchk("bypass timeout", `REG_FAULT, 8, 1'b1);
    bchk("estop timeout", `REG_STATUS, 4, 1'b1);
    bchk("motor dropped", `REG_STATUS, 0, 1'b0);
    cmd.bypass_switch <= 1'b0;
    settle(8);
    bchk("timeout cleared", `REG_FAULT, 8, 1'b0);
    cmd.move_cmd <= 1'b0;
    cmd.speed_a <= 16'h0000;
    cmd.speed_b <= 16'h0000;
    cmd.upper_emergency_terminal_switch <= 2'b00;
    cmd.inspection <= 1'b1;
    cmd.bypass_switch <= 1'b1;
    settle(70);
    bchk("no timeout inspecting", `REG_FAULT, 8, 1'b0);
    bchk("bypass honoured", `REG_STATUS, 5, 1'b1);
    cmd.inspection <= 1'b0;
    cmd.bypass_switch <= 1'b0;
    apb(1'b1, `REG_CTRL, 32'h20);
    cmd.door_open <= 1'b1;
    cmd.gate_open <= 1'b1;
    settle(4);
    cmd.at_floor <= 1'b0;
    settle(8);
    bchk("motion A", `REG_FAULT, 5, 1'b1);
    bchk("motion B", `REG_FAULT, 14, 1'b1);
    bchk("rope dropped", `REG_STATUS, 2, 1'b0);
    settle(40);
    bchk("motion held", `REG_FAULT, 5, 1'b1);
    cmd.fault_reset <= 1'b1;
    settle(6);
    cmd.fault_reset <= 1'b0;
    settle(6);
    bchk("motion reset", `REG_FAULT, 5, 1'b0);
    bchk("rope held", `REG_STATUS, 2, 1'b1);
    cmd.at_floor <= 1'b1;
    cmd.door_open <= 1'b0;
    cmd.gate_open <= 1'b0;
    cmd.bus_write_fail <= 2'b10;
    settle(8);
    bchk("bus fault B", `REG_FAULT, 15, 1'b1);
    bchk("bus fault A", `REG_FAULT, 6, 1'b0);
    bchk("bus estop", `REG_STATUS, 4, 1'b1);
    cmd.bus_write_fail <= 2'b00;
    cmd.car_string <= 1'b0;
    settle(8);
    bchk("string open", `REG_FAULT, 18, 1'b1);
    bchk("string no run", `REG_STATUS, 3, 1'b0);
    apb(1'b1, `REG_CTRL, 32'h8);
    cmd.test_mode <= 1'b1;
    settle(8);
    bchk("string bypass run", `REG_STATUS, 3, 1'b1);
    bchk("string still open", `REG_FAULT, 18, 1'b1);
    cmd.test_mode <= 1'b0;
    cmd.car_string <= 1'b1;
    apb(1'b1, `REG_CTRL, 32'h0);
    // The four stored-configuration problems are the low bits of the pin word, worst first.
    for (int i = 0; i < 4; i++) begin
      cmd[3 - i] <= 1'b1;
      settle(8);
      bchk("config fault", `REG_FAULT, 20 + i, 1'b1);
      bchk("config no run", `REG_STATUS, 3, 1'b0);
      cmd[3 - i] <= 1'b0;
      cmd.fault_reset <= 1'b1;
      settle(6);
      cmd.fault_reset <= 1'b0;
      settle(6);
    end
    cmd.jumper <= 1'b1;
    settle(30);
    cmd.jumper <= 1'b0;
    settle(4);
    cmd.jumper <= 1'b1;
    settle(30);
    bchk("jumper restarted", `REG_FAULT, 7, 1'b0);
    settle(20);
    bchk("jumper timeout A", `REG_FAULT, 7, 1'b1);
    bchk("jumper timeout B", `REG_FAULT, 16, 1'b1);
    bchk("jumper no restart", `REG_STATUS, 3, 1'b0);
    report_and_stop;
  end
endmodule
